// ### logic/sdh_defines.svh
// Register addresses, field positions and FIFO thresholds of the data status block.
`ifndef SDH_DEFINES_SVH
`define SDH_DEFINES_SVH
`define SDH_ADDR_REMAIN 32'h5a00_0030
`define SDH_ADDR_DSTATUS 32'h5a00_0034
`define SDH_ADDR_FSTATUS 32'h5a00_0038
`define SDH_RESET_VALUE 32'h0000_0000
`define SDH_BLKS_MSB 23
`define SDH_BLKS_LSB 12
`define SDH_BYTES_MSB 11
`define SDH_BYTES_LSB 0
`define SDH_BIT_READ_WAIT 10
`define SDH_BIT_CARD_IRQ 9
`define SDH_BIT_FIFO_ERR 8
`define SDH_BIT_TX_CRC 7
`define SDH_BIT_RX_CRC 6
`define SDH_BIT_TIMEOUT 5
`define SDH_BIT_DONE 4
`define SDH_BIT_BUSY_DONE 3
`define SDH_BIT_START_ERR 2
`define SDH_BIT_TX_ACTIVE 1
`define SDH_BIT_RX_ACTIVE 0
`define SDH_BIT_TX_SPACE 13
`define SDH_BIT_RX_AVAIL 12
`define SDH_BIT_TX_HALF 11
`define SDH_BIT_TX_EMPTY 10
`define SDH_BIT_RX_FINAL 9
`define SDH_BIT_RX_FULL 8
`define SDH_BIT_RX_HALF 7
`define SDH_FIFO_DEPTH 7'h40
`define SDH_TX_HALF_LIMIT 7'h21
`define SDH_RX_HALF_LIMIT 7'h1f
`endif

// ### logic/sdh_pkg.sv
// Types shared by the data status block.
package sdh_pkg;
    typedef enum logic [1:0] {
        SDH_MODE_IDLE = 2'h0,
        SDH_MODE_BUSY = 2'h1,
        SDH_MODE_RX = 2'h2,
        SDH_MODE_TX = 2'h3
    } sdh_mode_t;
    typedef logic [6:0] sdh_level_t;
endpackage

// ### logic/sdh_fifo_if.sv
// Status logic to FIFO level tracker signals.
`timescale 1ns/1ps
interface sdh_fifo_if;
    import sdh_pkg::*;
    logic push;
    logic pop;
    logic flush;
    sdh_level_t level;
    logic full;
    logic empty;
    logic overrun;
    logic underrun;
    modport tracker (input push, input pop, input flush, output level, output full,
        output empty, output overrun, output underrun);
    modport user (output push, output pop, output flush, input level, input full,
        input empty, input overrun, input underrun);
endinterface

// ### logic/sdh_sync.sv
// Two flip-flop synchroniser for pins from outside the clock domain.
`timescale 1ns/1ps
module sdh_sync import sdh_pkg::*; #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] stage_reg;

    // Only the second stage reads the first, so metastability settles.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            stage_reg <= '0;
            q <= '0;
        end else begin
            stage_reg <= d;
            q <= stage_reg;
        end
    end
endmodule

// ### logic/sdh_fifo_level.sv
// Byte level tracker of the 64-byte data FIFO with overrun and underrun detection.
`timescale 1ns/1ps
`include "sdh_defines.svh"
module sdh_fifo_level import sdh_pkg::*; (
    input wire logic clk,
    input wire logic nrst,
    sdh_fifo_if.tracker fifo
);
    sdh_level_t level_reg;
    sdh_level_t level_next;
    logic pushOk;
    logic popOk;

    // A push into a full FIFO needs a pop in the same cycle.
    always_comb begin
        popOk = fifo.pop && (level_reg != 7'h00);
        pushOk = fifo.push && ((level_reg != `SDH_FIFO_DEPTH) || popOk);
        level_next = level_reg;
        if (pushOk && !popOk) begin
            level_next = level_reg + 7'h01;
        end else if (popOk && !pushOk) begin
            level_next = level_reg - 7'h01;
        end
    end

    // A flush empties the FIFO when a new transfer starts.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            level_reg <= 7'h00;
        end else if (fifo.flush) begin
            level_reg <= 7'h00;
        end else begin
            level_reg <= level_next;
        end
    end

    assign fifo.level = level_reg;
    assign fifo.full = (level_reg == `SDH_FIFO_DEPTH);
    assign fifo.empty = (level_reg == 7'h00);
    assign fifo.overrun = fifo.push && !pushOk;
    assign fifo.underrun = fifo.pop && !popOk;
endmodule

// ### logic/sdh_status.sv
// Remaining counter, data status flags and FIFO status of the card data path.
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/1ps
`include "sdh_defines.svh"
// Functional notes
// [RULE1] Remaining blocks and bytes readable, reset zero.
// [RULE2] Read wait flag; write one stops request.
// [RULE3] Card interrupt sticky until written one.
// [RULE4] FIFO overrun, underrun, misalign set error flag.
// [RULE5] Transmit CRC status failure sets sticky flag.
// [RULE6] Receive CRC failure sets sticky flag.
// [RULE7] Receive or busy timeout sets sticky flag.
// [RULE8] Counter reaching zero sets done flag.
// [RULE9] Busy check completion sets sticky flag.
// [RULE10] Four-line start bit mismatch sets flag.
// [RULE11] Transmit in progress shown read-only.
// [RULE12] Receive in progress shown read-only.
// [RULE13] Transmit space flag below 64, DMA request.
// [RULE14] Receive data flag 1 to 64, DMA request.
// [RULE15] Transmit half flag below 33 bytes.
// [RULE16] Transmit empty flag at zero bytes.
// [RULE17] Receive final data flag after last byte.
// [RULE18] Receive full flag at 64 bytes.
// [RULE19] Receive half flag above 31 bytes.
// [RULE20] FIFO byte count readable in low bits.
// [RULE21] Mode selects idle, busy, receive, transmit.
// [RULE22] DMA enable turns availability into requests.
// [RULE23] Four-line mode checks all lines, else line zero.
// [RULE24] Zero writes and read-only writes change nothing.
// [RULE25] Counters load at start, count card bytes.
module sdh_status import sdh_pkg::*; (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [31:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdata,
    input wire logic [1:0] transferModeSelect,
    input wire logic dmaRequestEnable,
    input wire logic fourLineMode,
    input wire logic [11:0] blockCountCfg,
    input wire logic [11:0] blockSizeCfg,
    input wire logic cardClk,
    input wire logic [3:0] cardDataLines,
    input wire logic hostByteWr,
    input wire logic hostByteRd,
    input wire logic cardByte,
    input wire logic misalignedStore,
    input wire logic txCrcStatusFail,
    input wire logic rxCrcFail,
    input wire logic timeoutHit,
    input wire logic readWaitStart,
    input wire logic startBitCheck,
    output logic txDmaReq,
    output logic rxDmaReq,
    output logic readWaitDrive
);
    // ************************************************************
    // Register decode helpers
    // ************************************************************

    // Full-address compare; used by both the write and the read path.
    function automatic logic addrHit(input logic [31:0] addr, input logic [31:0] target);
        addrHit = (addr == target);
    endfunction

    sdh_mode_t mode;
    sdh_mode_t modePrev_reg;
    logic transferStart;
    logic modeRx;
    logic modeTx;

    // The mode field is decoded once and every direction flag follows it.
    always_comb begin
        mode = sdh_mode_t'(transferModeSelect); // [RULE21]
        modeRx = (mode == SDH_MODE_RX); // [RULE21]
        modeTx = (mode == SDH_MODE_TX); // [RULE21]
    end

    // Previous mode, to see a receive or transmit being started.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            modePrev_reg <= SDH_MODE_IDLE;
        end else begin
            modePrev_reg <= mode;
        end
    end

    assign transferStart = (modeRx || modeTx) && (mode != modePrev_reg);

    // ************************************************************
    // Card pins and link clock
    // ************************************************************

    logic [4:0] pinSync;
    logic linkClkPrev_reg;
    logic linkRise;
    logic [3:0] lineLevel;

    // Link clock and data pins pass two flops into this domain.
    sdh_sync #(.W(5)) pinSyncInst (
        .clk(clk),
        .nrst(nrst),
        .d({cardClk, cardDataLines}),
        .q(pinSync)
    );

    assign lineLevel = pinSync[3:0];

    // Edge finder on the synchronised link clock; 8 system clocks per link period.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            linkClkPrev_reg <= 1'b0;
        end else begin
            linkClkPrev_reg <= pinSync[4];
        end
    end

    assign linkRise = pinSync[4] && !linkClkPrev_reg;

    // ************************************************************
    // FIFO level
    // ************************************************************

    sdh_fifo_if fifoBus ();

    // Transmit fills from software and drains to the card; receive the reverse.
    assign fifoBus.push = modeTx ? hostByteWr : (modeRx && cardByte);
    assign fifoBus.pop = modeTx ? cardByte : (modeRx && hostByteRd);
    assign fifoBus.flush = transferStart;

    sdh_fifo_level fifoLevelInst (
        .clk(clk),
        .nrst(nrst),
        .fifo(fifoBus)
    );

    // ************************************************************
    // Remaining counters
    // ************************************************************

    logic [11:0] blocksLeft_reg;
    logic [11:0] bytesLeft_reg;
    logic lastByte;
    logic countCardByte;

    assign countCardByte = cardByte && (modeRx || modeTx);
    assign lastByte = countCardByte && (bytesLeft_reg == 12'h001) && (blocksLeft_reg <= 12'h001);

    // Load at start; a block boundary reloads the byte count.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            blocksLeft_reg <= 12'h000; // [RULE1]
            bytesLeft_reg <= 12'h000; // [RULE1]
        end else if (transferStart) begin
            blocksLeft_reg <= blockCountCfg; // [RULE25]
            bytesLeft_reg <= blockSizeCfg; // [RULE25]
        end else if (countCardByte && (bytesLeft_reg != 12'h000)) begin
            if (bytesLeft_reg != 12'h001) begin
                bytesLeft_reg <= bytesLeft_reg - 12'h001; // [RULE25]
            end else if (blocksLeft_reg > 12'h001) begin
                blocksLeft_reg <= blocksLeft_reg - 12'h001; // [RULE25]
                bytesLeft_reg <= blockSizeCfg;
            end else begin
                blocksLeft_reg <= 12'h000;
                bytesLeft_reg <= 12'h000;
            end
        end
    end

    // ************************************************************
    // Line checks on the link clock
    // ************************************************************

    logic startArm_reg;
    logic startBitBad;
    logic sawBusy_reg;
    logic busyEnd;
    logic cardIrq;

    // A start check waits for the next link edge; a new request re-arms it.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            startArm_reg <= 1'b0;
        end else if (startBitCheck) begin
            startArm_reg <= 1'b1;
        end else if (linkRise) begin
            startArm_reg <= 1'b0;
        end
    end

    // Only four-line mode can miss a start bit on some lines; line zero alone
    // always agrees with itself.
    assign startBitBad = startArm_reg && linkRise && fourLineMode
        && (lineLevel != 4'h0) && (lineLevel != 4'hf); // [RULE10] [RULE23]

    // Busy is line zero held low; its release ends a busy-check-only operation.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sawBusy_reg <= 1'b0;
        end else if (mode != SDH_MODE_BUSY) begin
            sawBusy_reg <= 1'b0;
        end else if (linkRise) begin
            sawBusy_reg <= !lineLevel[0];
        end
    end

    assign busyEnd = (mode == SDH_MODE_BUSY) && sawBusy_reg && linkRise && lineLevel[0]; // [RULE9]

    // Card interrupt is line one low while no data moves on the lines.
    assign cardIrq = linkRise && (mode == SDH_MODE_IDLE) && !lineLevel[1]; // [RULE3]

    // ************************************************************
    // Sticky event flags
    // ************************************************************

    logic [10:2] flagSet;
    logic [10:2] flag_reg;
    logic statusWrite;

    assign statusWrite = regWr && addrHit(regAddr, `SDH_ADDR_DSTATUS);

    // Event sources, one per sticky bit.
    always_comb begin
        flagSet = '0;
        flagSet[`SDH_BIT_READ_WAIT] = readWaitStart && modeRx; // [RULE2]
        flagSet[`SDH_BIT_CARD_IRQ] = cardIrq; // [RULE3]
        flagSet[`SDH_BIT_FIFO_ERR] = fifoBus.overrun || fifoBus.underrun
            || misalignedStore; // [RULE4]
        flagSet[`SDH_BIT_TX_CRC] = txCrcStatusFail && modeTx; // [RULE5]
        flagSet[`SDH_BIT_RX_CRC] = rxCrcFail && modeRx; // [RULE6]
        flagSet[`SDH_BIT_TIMEOUT] = timeoutHit && (modeRx || mode == SDH_MODE_BUSY); // [RULE7]
        flagSet[`SDH_BIT_DONE] = lastByte; // [RULE8]
        flagSet[`SDH_BIT_BUSY_DONE] = busyEnd; // [RULE9]
        flagSet[`SDH_BIT_START_ERR] = startBitBad; // [RULE10]
    end

    // Each flag clears on a written one and keeps on a zero; a set in the
    // clearing cycle wins so no event is lost.
    genvar gi;
    generate
        for (gi = 2; gi <= 10; gi++) begin : gFlag
            always_ff @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    flag_reg[gi] <= 1'b0;
                end else if (flagSet[gi]) begin
                    flag_reg[gi] <= 1'b1;
                end else if (statusWrite && regWdata[gi]) begin
                    flag_reg[gi] <= 1'b0; // [RULE24]
                end
            end
        end
    endgenerate

    // The read wait drive to the card follows its flag, so clearing stops it.
    assign readWaitDrive = flag_reg[`SDH_BIT_READ_WAIT]; // [RULE2]

    // ************************************************************
    // Progress and final data indications
    // ************************************************************

    logic txActive_reg;
    logic rxActive_reg;
    logic rxFinal_reg;

    // Progress holds from start until the last byte or a change to idle or busy mode.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            txActive_reg <= 1'b0;
            rxActive_reg <= 1'b0;
        end else if (transferStart) begin
            txActive_reg <= modeTx; // [RULE11]
            rxActive_reg <= modeRx; // [RULE12]
        end else if (lastByte || (!modeRx && !modeTx)) begin
            txActive_reg <= 1'b0; // [RULE11]
            rxActive_reg <= 1'b0; // [RULE12]
        end
    end

    // Final data stays until software has drained the receive FIFO.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rxFinal_reg <= 1'b0;
        end else if (transferStart) begin
            rxFinal_reg <= 1'b0;
        end else if (lastByte && modeRx) begin
            rxFinal_reg <= 1'b1; // [RULE17]
        end else if (fifoBus.empty) begin
            rxFinal_reg <= 1'b0;
        end
    end

    // ************************************************************
    // FIFO status flags and DMA requests
    // ************************************************************

    logic txSpace;
    logic rxAvail;
    logic [31:0] fifoWord;

    assign txSpace = modeTx && !fifoBus.full; // [RULE13]
    assign rxAvail = modeRx && !fifoBus.empty; // [RULE14]

    // Without DMA software polls the same two flags instead.
    assign txDmaReq = dmaRequestEnable && txSpace; // [RULE13] [RULE22]
    assign rxDmaReq = dmaRequestEnable && rxAvail; // [RULE14] [RULE22]

    // One shared level serves both directions, so the half flags compare it.
    always_comb begin
        fifoWord = '0;
        fifoWord[`SDH_BIT_TX_SPACE] = txSpace;
        fifoWord[`SDH_BIT_RX_AVAIL] = rxAvail;
        fifoWord[`SDH_BIT_TX_HALF] = modeTx
            && (fifoBus.level < `SDH_TX_HALF_LIMIT); // [RULE15]
        fifoWord[`SDH_BIT_TX_EMPTY] = modeTx && fifoBus.empty; // [RULE16]
        fifoWord[`SDH_BIT_RX_FINAL] = rxFinal_reg; // [RULE17]
        fifoWord[`SDH_BIT_RX_FULL] = modeRx && fifoBus.full; // [RULE18]
        fifoWord[`SDH_BIT_RX_HALF] = modeRx
            && (fifoBus.level > `SDH_RX_HALF_LIMIT); // [RULE19]
        fifoWord[6:0] = fifoBus.level; // [RULE20]
    end

    // ************************************************************
    // Register read port
    // ************************************************************

    logic [31:0] readMux;

    // Only the clear bits are writable; other writes are dropped.
    // Unmapped reads return zero.
    always_comb begin
        readMux = `SDH_RESET_VALUE;
        if (addrHit(regAddr, `SDH_ADDR_REMAIN)) begin
            readMux[`SDH_BLKS_MSB:`SDH_BLKS_LSB] = blocksLeft_reg; // [RULE1]
            readMux[`SDH_BYTES_MSB:`SDH_BYTES_LSB] = bytesLeft_reg; // [RULE1]
        end else if (addrHit(regAddr, `SDH_ADDR_DSTATUS)) begin
            readMux[10:2] = flag_reg;
            readMux[`SDH_BIT_TX_ACTIVE] = txActive_reg; // [RULE11]
            readMux[`SDH_BIT_RX_ACTIVE] = rxActive_reg; // [RULE12]
        end else if (addrHit(regAddr, `SDH_ADDR_FSTATUS)) begin
            readMux = fifoWord;
        end
    end

    // Read data stands for the one cycle after the strobe, zero otherwise.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            regRdata <= `SDH_RESET_VALUE;
        end else if (regRd) begin
            regRdata <= readMux;
        end else begin
            regRdata <= `SDH_RESET_VALUE;
        end
    end
endmodule

// ### verif/sdh_status_monitor.sv
// Checker of the data status block's top-level ports.
`timescale 1ns/1ps
`include "sdh_defines.svh"
module sdh_status_monitor import sdh_pkg::*; (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [31:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [31:0] regRdata,
    input wire logic [1:0] transferModeSelect,
    input wire logic dmaRequestEnable,
    input wire logic readWaitStart,
    input wire logic txDmaReq,
    input wire logic rxDmaReq,
    input wire logic readWaitDrive
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);
    // ********************
    // Properties
    // ********************
    // Decoded accesses.
    logic rdS;
    logic rdF;
    logic clrWait;
    assign rdS = regRd && regAddr == `SDH_ADDR_DSTATUS;
    assign rdF = regRd && regAddr == `SDH_ADDR_FSTATUS;
    assign clrWait = regWr && regAddr == `SDH_ADDR_DSTATUS && regWdata[10];
    a_rdata_idle: assert property (!$past(regRd) |-> regRdata == 32'h0000_0000)
        else $error("read data not zero outside a read slot");
    a_txreq_cause: assert property (txDmaReq |-> dmaRequestEnable && transferModeSelect == 2'h3)
        else $error("transmit request without cause");
    a_rxreq_cause: assert property (rxDmaReq |-> dmaRequestEnable && transferModeSelect == 2'h2)
        else $error("receive request without cause");
    a_wait_raise: assert property (readWaitStart && transferModeSelect == 2'h2 |=> readWaitDrive)
        else $error("read wait not driven");
    a_wait_clear: assert property (clrWait && !readWaitStart |=> !readWaitDrive)
        else $error("read wait not stopped");
    a_wait_hold: assert property (readWaitDrive && !clrWait |=> readWaitDrive)
        else $error("read wait dropped by itself");
    a_wait_shown: assert property (rdS |=> regRdata[10] == $past(readWaitDrive))
        else $error("read wait flag differs from pin");
    a_status_reserved: assert property (rdS |=> regRdata[31:11] == 21'h00_0000)
        else $error("reserved status bits set");
    a_tx_levels: assert property (rdF && transferModeSelect == 2'h3 |=>
        regRdata[10] == (regRdata[6:0] == 7'h00) && regRdata[11] == (regRdata[6:0] < 7'h21))
        else $error("transmit level flags wrong");
    a_rx_levels: assert property (rdF && transferModeSelect == 2'h2 |=>
        regRdata[8] == (regRdata[6:0] == 7'h40) && regRdata[7] == (regRdata[6:0] > 7'h1f))
        else $error("receive level flags wrong");
    a_tx_space: assert property (rdF && transferModeSelect == 2'h3 && dmaRequestEnable
        |=> regRdata[13] == $past(txDmaReq))
        else $error("transmit space flag differs from request");
    c_wait_cycle: cover property (readWaitDrive ##1 !readWaitDrive);
    c_tx_full: cover property ($fell(txDmaReq));
    c_rx_full: cover property (rdF ##1 regRdata[8]);
endmodule
bind sdh_status sdh_status_monitor i_mon (
    .clk(clk), .nrst(nrst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRdata(regRdata), .transferModeSelect(transferModeSelect),
    .dmaRequestEnable(dmaRequestEnable), .readWaitStart(readWaitStart),
    .txDmaReq(txDmaReq), .rxDmaReq(rxDmaReq), .readWaitDrive(readWaitDrive)
);

// ### verif/sdh_card_model.sv
// Card side: gated link clock and pulled-up data lines.
`timescale 1ns/1ps
module sdh_card_model (
    output logic cardClk,
    output logic [3:0] cardDataLines
);
    // Clock idles low between frames; released lines sit high.
    initial begin
        cardClk = 1'h0;
        cardDataLines = 4'hf;
    end
    // Two 320 ns link periods, one value per rise, off the host edge.
    task automatic send(input logic [3:0] a, input logic [3:0] b);
        #7 cardDataLines = a;
        #160 cardClk = 1'h1;
        #160 cardClk = 1'h0;
        cardDataLines = b;
        #160 cardClk = 1'h1;
        #160 cardClk = 1'h0;
        cardDataLines = 4'hf;
    endtask
endmodule

// ### verif/sdh_status_test.sv
// Self-checking bench of the data status block.
`timescale 1ns/1ps
`include "sdh_defines.svh"
module sdh_status_test import sdh_pkg::*;;
    localparam logic [31:0] AC = `SDH_ADDR_REMAIN;
    localparam logic [31:0] AS = `SDH_ADDR_DSTATUS;
    localparam logic [31:0] AF = `SDH_ADDR_FSTATUS;
    logic clk;
    logic nrst = 1'h0;
    logic [31:0] regAddr = 32'h0000_0000;
    logic [31:0] regWdata = 32'h0000_0000;
    logic regWr = 1'h0;
    logic regRd = 1'h0;
    logic [31:0] regRdata;
    logic [1:0] mode = 2'h0;
    logic dmaEn = 1'h0;
    logic fourLine = 1'h0;
    logic [11:0] bytes_left_in_block = 12'h000;
    logic [11:0] blkSize = 12'h000;
    logic cardClk;
    logic [3:0] cardDataLines;
    logic [8:0] ev = 9'h000;
    logic txDmaReq;
    logic rxDmaReq;
    logic readWaitDrive;
    int n_fail = 0;
    int checked = 0;
    int cyc = 0;
    int evt[4] = '{5, 6, 7, 3};
    int bits[4] = '{6, 5, 10, 8};
    sdh_status i_dut (
        .clk(clk), .nrst(nrst), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
        .transferModeSelect(mode), .dmaRequestEnable(dmaEn), .fourLineMode(fourLine),
        .blockCountCfg(bytes_left_in_block), .blockSizeCfg(blkSize), .cardClk(cardClk),
        .cardDataLines(cardDataLines), .hostByteWr(ev[0]), .hostByteRd(ev[1]),
        .cardByte(ev[2]), .misalignedStore(ev[3]), .txCrcStatusFail(ev[4]),
        .rxCrcFail(ev[5]), .timeoutHit(ev[6]), .readWaitStart(ev[7]),
        .startBitCheck(ev[8]), .txDmaReq(txDmaReq), .rxDmaReq(rxDmaReq),
        .readWaitDrive(readWaitDrive)
    );
    sdh_card_model i_card (
        .cardClk(cardClk),
        .cardDataLines(cardDataLines)
    );
    // ********************
    // Clock, timeout and tasks
    // ********************
    initial begin
        clk = 1'h0;
        forever #20 clk = ~clk;
    end
    // Hang guard, far above the run's well under one thousand cycles.
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail = n_fail + 1;
            results();
        end
    end
    task automatic results();
        $display("Comparisons %0d, mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checked = checked + 1;
        if (got !== exp) begin
            n_fail = n_fail + 1;
            $display("Error at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'h1;
        @(posedge clk);
        regWr <= 1'h0;
    endtask
    // Read data stand only in the cycle after the strobe.
    task automatic ck(input logic [31:0] a, input logic [31:0] exp);
        @(posedge clk);
        regAddr <= a;
        regRd <= 1'h1;
        @(posedge clk);
        regRd <= 1'h0;
        #1 check(regRdata, exp);
    endtask
    // One-cycle event pulses, each followed by a gap.
    task automatic pulse(input int i, input int n);
        repeat (n) begin
            @(posedge clk);
            ev[i] <= 1'h1;
            @(posedge clk);
            ev[i] <= 1'h0;
        end
    endtask
    task automatic setm(input logic [1:0] m, input logic [11:0] c, input logic [11:0] s);
        @(posedge clk);
        bytes_left_in_block <= c;
        blkSize <= s;
        mode <= m;
        repeat (2) @(posedge clk);
    endtask
    task automatic frame(input logic [3:0] a);
        i_card.send(a, 4'hf);
        repeat (6) @(posedge clk);
    endtask
    // Expected FIFO status for a mode, level and final flag.
    function automatic logic [31:0] fs(input logic [1:0] m, input int n, input logic fin);
        fs = {25'h000_0000, 7'(n)};
        if (m == SDH_MODE_TX) begin
            fs[13] = n < 64;
            fs[11] = n < 33;
            fs[10] = n == 0;
        end else if (m == SDH_MODE_RX) begin
            fs[12] = n > 0;
            fs[9] = fin;
            fs[8] = n == 64;
            fs[7] = n > 31;
        end
    endfunction
    // ********************
    // Tests
    // ********************
    initial begin
        repeat (4) @(posedge clk);
        nrst <= 1'h1;
        ck(AC, 32'h0000_0000);
        wr(AC, 32'hffff_ffff);
        wr(AS, 32'hffff_ffff);
        wr(AF, 32'hffff_ffff);
        ck(AC, 32'h0000_0000);
        ck(AS, 32'h0000_0000);
        ck(AF, 32'h0000_0000);
        ck(32'h5a00_003c, 32'h0000_0000);
        $display("test reset done");
        dmaEn <= 1'h1;
        setm(SDH_MODE_RX, 12'h002, 12'h028);
        ck(AC, 32'h0000_2028);
        ck(AS, 32'h0000_0001);
        for (int i = 1; i <= 64; i++) begin
            pulse(2, 1);
            if (i == 31 || i == 32 || i > 62) ck(AF, fs(mode, i, 1'h0));
        end
        check(rxDmaReq, 32'h0000_0001);
        ck(AC, 32'h0000_1010);
        pulse(2, 1);
        ck(AS, 32'h0000_0101);
        pulse(1, 64);
        ck(AF, 32'h0000_0000);
        pulse(2, 15);
        ck(AC, 32'h0000_0000);
        ck(AS, 32'h0000_0110);
        ck(AF, fs(mode, 15, 1'h1));
        wr(AS, 32'h0000_0010);
        ck(AS, 32'h0000_0100);
        wr(AS, 32'h0000_0100);
        pulse(1, 16);
        ck(AS, 32'h0000_0100);
        ck(AF, 32'h0000_0000);
        wr(AS, 32'h0000_0100);
        $display("test receive done");
        setm(SDH_MODE_IDLE, 12'h000, 12'h000);
        setm(SDH_MODE_TX, 12'h001, 12'h040);
        ck(AS, 32'h0000_0002);
        for (int i = 0; i <= 64; i++) begin
            if (i > 0) pulse(0, 1);
            if (i < 2 || i == 32 || i == 33 || i > 62) begin
                ck(AF, fs(mode, i, 1'h0));
                check(txDmaReq, 32'(i < 64));
            end
        end
        pulse(4, 1);
        pulse(5, 1);
        ck(AS, 32'h0000_0082);
        pulse(2, 64);
        ck(AS, 32'h0000_0090);
        ck(AF, fs(mode, 0, 1'h0));
        dmaEn <= 1'h0;
        @(posedge clk);
        check(txDmaReq, 32'h0000_0000);
        wr(AS, 32'h0000_0090);
        $display("test transmit done");
        setm(SDH_MODE_RX, 12'h001, 12'h008);
        foreach (evt[k]) begin
            pulse(evt[k], 1);
            #1 check(readWaitDrive, 32'(bits[k] == 10));
            ck(AS, 32'h0000_0001 | (32'h0000_0001 << bits[k]));
            wr(AS, 32'h0000_0000);
            ck(AS, 32'h0000_0001 | (32'h0000_0001 << bits[k]));
            wr(AS, 32'h0000_0001 << bits[k]);
            ck(AS, 32'h0000_0001);
            check(readWaitDrive, 32'h0000_0000);
        end
        pulse(8, 1);
        frame(4'ha);
        ck(AS, 32'h0000_0001);
        fourLine <= 1'h1;
        pulse(8, 1);
        frame(4'ha);
        ck(AS, 32'h0000_0005);
        wr(AS, 32'h0000_0004);
        setm(SDH_MODE_BUSY, 12'h000, 12'h000);
        pulse(6, 1);
        frame(4'he);
        ck(AS, 32'h0000_0028);
        wr(AS, 32'h0000_0028);
        setm(SDH_MODE_IDLE, 12'h000, 12'h000);
        frame(4'hd);
        ck(AS, 32'h0000_0200);
        wr(AS, 32'h0000_0200);
        ck(AS, 32'h0000_0000);
        $display("test events done");
        results();
    end
endmodule
